// File: common/psi_pkg.sv
package psi_pkg;
   typedef enum logic [1:0] {
      PSI_MODE_1,
      PSI_MODE_2,
      PSI_MODE_3
   } psi_mode_e;

   typedef enum logic [1:0] {
      PSI_HB_IDLE,
      PSI_HB_WAIT,
      PSI_HB_PULSE
   } psi_hb_e;
endpackage

// File: common/psi_regs.svh
// Operation
// [R01] MII carrier sense follows receive medium activity
// [R02] RMII output merges carrier and data valid
// [R03] Half duplex collision on simultaneous transmit, receive
// [R04] 10BASE-T heartbeat pulse about 1us after transmit; here the 1us pulse starts on col two cycles after transmit ends
// [R05] Full duplex: collision always low, no heartbeat
// [R06] RMII MAC derives collision itself from carrier
// [R07] Three indicators; strap modes plus register mode
// [R08] Mode 1 link indicator shows link good
// [R09] Modes 2,3 link indicator blinks on activity
// [R10] Speed indicator on at 100, any mode
// [R11] Mode 1 activity indicator shows any activity
// [R12] Mode 2 activity indicator shows collision
// [R13] Mode 3 activity indicator shows full duplex
// [R14] Blink uses fixed visible period from clock
`ifndef PSI_REGS_SVH
`define PSI_REGS_SVH

// ****************************************
// Register map
// ****************************************
`define PSI_REG_CTRL         4'h0
`define PSI_REG_STATUS       4'h1
`define PSI_CTRL_MODE3_BIT   0
`define PSI_CTRL_HB_EN_BIT   1
`define PSI_CTRL_RESET       8'h02

// ****************************************
// Timing
// ****************************************
`define PSI_CLK_MHZ          100
`define PSI_HB_NS            1000
`define PSI_HB_CYCLES        ((`PSI_HB_NS * `PSI_CLK_MHZ) / 1000)
`define PSI_BLINK_MS         50
`define PSI_BLINK_CYCLES     (`PSI_BLINK_MS * `PSI_CLK_MHZ * 1000)

`endif

// File: common/psi_stat_if.sv
`timescale 1ns/1ps
interface psi_stat_if;
   logic tx_act;
   logic rx_act;
   logic link_up;
   logic speed_100;
   logic full_dup;
   logic col;
   modport src (output tx_act, output rx_act, output link_up, output speed_100,
                output full_dup, input col);
   modport dst (input tx_act, input rx_act, input link_up, input speed_100,
                input full_dup, output col);
endinterface

// File: hdl/psi_blink.sv
`timescale 1ns/1ps
`include "psi_regs.svh"
module psi_blink #(
   parameter int PERIOD = `PSI_BLINK_CYCLES
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rstn,
   input  wire logic i_ce,
   input  wire logic i_act,
   output logic      o_blink
);
   logic [31:0] cnt;
   logic        busy;

   // Latch activity so a short burst still gives one full visible off phase
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt     <= 32'h0000_0000;
         busy    <= 1'b0;
         o_blink <= 1'b0;
      end else if (i_ce) begin
         if (busy) begin
            if (cnt == 32'(PERIOD - 1)) begin  // see [R14]
               cnt     <= 32'h0000_0000;
               o_blink <= ~o_blink;
               busy    <= i_act | ~o_blink;
            end else begin
               cnt <= cnt + 32'h0000_0001;
            end
         end else if (i_act) begin
            busy <= 1'b1;
         end
      end
   end
endmodule

// File: hdl/psi_collision.sv
`timescale 1ns/1ps
`include "psi_regs.svh"
module psi_collision #(
   parameter int HB_CYCLES = `PSI_HB_CYCLES
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rstn,
   input  wire logic i_ce,
   input  wire logic i_hb_en,
   psi_stat_if.dst   st,
   output logic      o_col
);
   import psi_pkg::*;

   psi_hb_e     state;
   logic [15:0] cnt;
   logic        tx_d;

   wire tx_end   = tx_d & ~st.tx_act;
   wire hb_ok    = i_hb_en & ~st.speed_100 & ~st.full_dup;  // see [R04] see [R05]
   wire overlap  = st.tx_act & st.rx_act & ~st.full_dup;    // see [R03] see [R05]
   // Pulse cut at once if duplex or speed changes mid-beat
   wire next_col = overlap | ((state == PSI_HB_PULSE) & hb_ok);  // see [R05]

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state <= PSI_HB_IDLE;
         cnt   <= 16'h0000;
         tx_d  <= 1'b0;
         o_col <= 1'b0;
      end else if (i_ce) begin
         tx_d  <= st.tx_act;
         o_col <= next_col;
         case (state)
            PSI_HB_IDLE: begin
               if (tx_end && hb_ok) begin
                  state <= PSI_HB_PULSE;  // see [R04]
                  cnt   <= 16'(HB_CYCLES - 1);
               end
            end
            PSI_HB_PULSE: begin
               if (!hb_ok || cnt == 16'h0000) begin
                  state <= PSI_HB_IDLE;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            default: state <= PSI_HB_IDLE;
         endcase
      end
   end

   assign st.col = o_col;
endmodule

// File: hdl/psi_top.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "psi_regs.svh"
module psi_top #(
   parameter int BLINK_CYCLES = `PSI_BLINK_CYCLES,
   parameter int HB_CYCLES    = `PSI_HB_CYCLES
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   input  wire logic        i_rmii,
   input  wire logic        i_mode_strap,
   input  wire logic        i_rx_carrier,
   input  wire logic        i_rx_dv,
   input  wire logic        i_tx_en,
   input  wire logic        i_link_up,
   input  wire logic        i_speed_100,
   input  wire logic        i_full_dup,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   output logic             o_crs,
   output logic             o_col,
   output logic             o_link_indicator,
   output logic             o_speed_indicator,
   output logic             o_activity_indicator,
   output psi_pkg::psi_mode_e o_mode
);
   import psi_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ctrl;
   logic       strap;
   logic       strap_taken;
   logic       rmii_toggle;

   psi_stat_if st ();
   assign st.tx_act    = i_tx_en;
   assign st.rx_act    = i_rx_carrier;
   assign st.link_up   = i_link_up;
   assign st.speed_100 = i_speed_100;
   assign st.full_dup  = i_full_dup;

   wire wr_ctrl = i_wr && (i_addr == `PSI_REG_CTRL);

   // Strap caught on first enabled edge after reset release
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap       <= 1'b0;
         strap_taken <= 1'b0;
      end else if (i_ce && !strap_taken) begin
         strap       <= i_mode_strap;
         strap_taken <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl <= `PSI_CTRL_RESET;
      end else if (i_ce && wr_ctrl) begin
         ctrl <= i_wdata;
      end
   end

   wire mode3 = ctrl[`PSI_CTRL_MODE3_BIT];
   wire hb_en = ctrl[`PSI_CTRL_HB_EN_BIT];

   // Register mode overrides both strap modes
   wire psi_mode_e mode = mode3 ? PSI_MODE_3 :
                          (strap ? PSI_MODE_2 : PSI_MODE_1);  // see [R07]

   wire [7:0] status = {2'b00, mode, i_full_dup, i_speed_100, i_link_up, o_col};

   wire [7:0] next_rdata = (i_addr == `PSI_REG_CTRL)   ? ctrl   :
                           (i_addr == `PSI_REG_STATUS) ? status : 8'h00;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= i_rd ? next_rdata : 8'h00;
      end
   end

   // ****************************************
   // Carrier sense
   // ****************************************
   // RMII: carrier alone on the assert side; once carrier drops while data is
   // still draining, alternate with data valid on 2-bit boundaries.
   wire next_crs = !i_rmii ? i_rx_carrier :                      // see [R01]
                   i_rx_carrier ? 1'b1 :
                   (i_rx_dv ? rmii_toggle : 1'b0);                // see [R02]

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_crs       <= 1'b0;
         rmii_toggle <= 1'b0;
      end else if (i_ce) begin
         o_crs       <= next_crs;
         rmii_toggle <= (i_rx_carrier || !i_rx_dv) ? 1'b0 : ~rmii_toggle;
      end
   end

   // ****************************************
   // Collision
   // ****************************************
   // RMII MAC derives collision itself; the pin stays meaningful for MII only
   logic col_raw;

   psi_collision #(
      .HB_CYCLES (HB_CYCLES)
   ) u_col (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_ce      (i_ce),
      .i_hb_en   (hb_en),
      .st        (st.dst),
      .o_col     (col_raw)
   );

   assign o_col = col_raw & ~i_rmii;  // see [R06]

   // ****************************************
   // Indicators
   // ****************************************
   logic blink;

   psi_blink #(
      .PERIOD (BLINK_CYCLES)
   ) u_blink (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_ce      (i_ce),
      .i_act     (i_tx_en | i_rx_carrier),
      .o_blink   (blink)
   );

   wire any_act   = i_tx_en | i_rx_carrier;
   wire next_link = (mode == PSI_MODE_1) ? i_link_up :           // see [R08]
                    (i_link_up & ~blink);                        // see [R09]
   wire next_act  = (mode == PSI_MODE_1) ? any_act :             // see [R11]
                    (mode == PSI_MODE_2) ? col_raw :              // see [R12]
                    i_full_dup;                                  // see [R13]

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_link_indicator     <= 1'b0;
         o_speed_indicator    <= 1'b0;
         o_activity_indicator <= 1'b0;
      end else if (i_ce) begin
         o_link_indicator     <= next_link;
         o_speed_indicator    <= i_speed_100;  // see [R10]
         o_activity_indicator <= next_act;
      end
   end

   assign o_mode = mode;
endmodule

// File: tb/psi_mac_model.sv
`timescale 1ns/1ps
module psi_mac_model (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_send,
   input  wire logic [7:0] i_len,
   input  wire logic       i_rmii,
   input  wire logic       i_crs,
   input  wire logic       i_col,
   output logic            o_tx_en,
   output logic            o_col_seen
);
   logic [7:0] left;
   assign o_tx_en = left != 8'h00;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         left <= 8'h00;
         o_col_seen <= 1'b0;
      end else if (i_send) begin
         left <= i_len;
         o_col_seen <= 1'b0;
      end else if (o_tx_en) begin
         left <= left - 8'h01;
         // No collision pin in RMII: carrier comes from the merged line
         if (i_rmii ? i_crs : i_col) o_col_seen <= 1'b1;
      end
   end
endmodule

// File: tb/psi_top_bench.sv
`timescale 1ns/1ps
module psi_top_bench;
   import psi_pkg::*;
   logic       clk = 1'b0, rstn = 1'b0, strap = 1'b0, rmii = 1'b0, car = 1'b0, dv = 1'b0;
   logic       link = 1'b1, spd = 1'b1, fd = 1'b0, wr = 1'b0, rd = 1'b0, send = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, len = 8'h00, rdata;
   logic       tx_en, col_seen, crs, col, lnk_i, spd_i, act_i, prev;
   psi_mode_e  mode;
   int         n_errors = 0, compares = 0, ccol, cact, cnl;
   psi_top #(.BLINK_CYCLES(8), .HB_CYCLES(4)) i_psi_top (.i_sys_clk(clk), .i_rstn(rstn),
      .i_ce(1'b1), .i_rmii(rmii), .i_mode_strap(strap), .i_rx_carrier(car), .i_rx_dv(dv),
      .i_tx_en(tx_en), .i_link_up(link), .i_speed_100(spd), .i_full_dup(fd), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_crs(crs), .o_col(col),
      .o_link_indicator(lnk_i), .o_speed_indicator(spd_i), .o_activity_indicator(act_i),
      .o_mode(mode));
   psi_mac_model i_psi_mac_model (.i_sys_clk(clk), .i_rstn(rstn), .i_send(send), .i_len(len),
      .i_rmii(rmii), .i_crs(crs), .i_col(col), .o_tx_en(tx_en), .o_col_seen(col_seen));
   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_reg(logic [3:0] a, logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask
   task automatic wr_ctrl(logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= 4'h0;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic frame(logic [7:0] l, logic c);
      @(posedge clk);
      car <= c;
      send <= 1'b1;
      len <= l;
      @(posedge clk);
      send <= 1'b0;
      {ccol, cact, cnl} = '0;
      // Sample mid-cycle so registered outputs have settled
      repeat (int'(l) + 12) begin
         @(negedge clk);
         ccol += int'(col);
         cact += int'(act_i);
         cnl += int'(!lnk_i);
      end
      @(posedge clk);
      car <= 1'b0;
   endtask
   task automatic do_reset(logic s);
      @(posedge clk);
      rstn <= 1'b0;
      strap <= s;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
   endtask
   task automatic wrap_up;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial forever #5 clk = ~clk;
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      wrap_up;
   end
   initial begin
      do_reset(1'b0);
      rd_reg(4'h0, 8'h02);
      rd_reg(4'h1, 8'h06);
      rd_reg(4'h9, 8'h00);
      frame(8'd6, 1'b1);
      spd <= 1'b0;
      #1 chk("crs", 8'h01, {7'h0, crs});
      chk("col", 8'd6, 8'(ccol));
      chk("mac col", 8'h01, {7'h0, col_seen});
      chk("link off", 8'd0, 8'(cnl));
      frame(8'd3, 1'b0);
      chk("beat", 8'd4, 8'(ccol));
      chk("act", 8'd3, 8'(cact));
      #1 chk("speed", 8'h00, {7'h0, spd_i});
      chk("crs", 8'h00, {7'h0, crs});
      wr_ctrl(8'h00);
      frame(8'd3, 1'b0);
      chk("beat off", 8'd0, 8'(ccol));
      wr_ctrl(8'h02);
      fd <= 1'b1;
      frame(8'd6, 1'b1);
      chk("col full", 8'd0, 8'(ccol));
      @(posedge clk);
      {rmii, fd} <= 2'b10;
      frame(8'd6, 1'b1);
      chk("col rmii", 8'd0, 8'(ccol));
      chk("mac col", 8'h01, {7'h0, col_seen});
      dv <= 1'b1;
      repeat (3) @(negedge clk);
      prev = crs;
      @(negedge clk);
      chk("crs toggle", 8'h01, {7'h0, prev ^ crs});
      chk("crs drain", 8'h00, {7'h0, crs});
      @(posedge clk);
      {rmii, dv, fd} <= 3'b001;
      wr_ctrl(8'h03);
      rd_reg(4'h1, 8'h2A);
      frame(8'd40, 1'b0);
      chk("duplex", 8'd52, 8'(cact));
      chk("blink", 8'h01, {7'h0, cnl > 0});
      do_reset(1'b1);
      @(posedge clk);
      {spd, fd} <= 2'b10;
      #1 chk("mode", 8'h01, {6'h0, mode});
      frame(8'd6, 1'b1);
      chk("act col", 8'd6, 8'(cact));
      wrap_up;
   end
endmodule
bind psi_top psi_top_props #(.BLINK_CYCLES(BLINK_CYCLES), .HB_CYCLES(HB_CYCLES))
   i_psi_top_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_rmii(i_rmii),
   .i_rx_carrier(i_rx_carrier), .i_rx_dv(i_rx_dv), .i_tx_en(i_tx_en), .i_link_up(i_link_up),
   .i_speed_100(i_speed_100), .i_full_dup(i_full_dup), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .o_crs(o_crs), .o_col(o_col), .o_link_indicator(o_link_indicator),
   .o_speed_indicator(o_speed_indicator), .o_activity_indicator(o_activity_indicator),
   .o_mode(o_mode));

// File: tb/psi_top_props.sv
`timescale 1ns/1ps
`include "psi_regs.svh"
module psi_top_props
   import psi_pkg::*;
#(
   parameter int BLINK_CYCLES = 8,
   parameter int HB_CYCLES    = 4
) (
   input  wire logic      i_sys_clk,
   input  wire logic      i_rstn,
   input  wire logic      i_ce,
   input  wire logic      i_rmii,
   input  wire logic      i_rx_carrier,
   input  wire logic      i_rx_dv,
   input  wire logic      i_tx_en,
   input  wire logic      i_link_up,
   input  wire logic      i_speed_100,
   input  wire logic      i_full_dup,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic      i_wr,
   input  wire logic      o_crs,
   input  wire logic      o_col,
   input  wire logic      o_link_indicator,
   input  wire logic      o_speed_indicator,
   input  wire logic      o_activity_indicator,
   input  wire psi_mode_e o_mode
);
   // ****************************************
   // Status path checks
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   logic hb_en;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) hb_en <= 1'b1;
      else if (i_ce && i_wr && i_addr == `PSI_REG_CTRL) hb_en <= i_wdata[`PSI_CTRL_HB_EN_BIT];
   end
   a_crs_mii_follow: assert property (
      i_ce && !i_rmii |=> o_crs == $past(i_rx_carrier))
      else $error("carrier sense wrong");
   a_crs_rmii_on: assert property (
      i_ce && i_rmii && i_rx_carrier |=> o_crs)
      else $error("merged carrier low");
   a_crs_rmii_off: assert property (
      i_ce && i_rmii && !i_rx_carrier && !i_rx_dv |=> !o_crs)
      else $error("merged carrier stuck high");
   a_col_rmii_low: assert property (
      i_rmii |-> !o_col)
      else $error("collision in RMII");
   a_col_half_dup: assert property (
      i_ce && !i_rmii && !i_full_dup && i_tx_en && i_rx_carrier |=> o_col || i_rmii)
      else $error("collision missed");
   a_col_full_low: assert property (
      i_full_dup && $past(i_full_dup) |-> !o_col)
      else $error("collision in full duplex");
   a_beat_after_tx: assert property (
      $fell(i_tx_en) && hb_en && !i_speed_100 && !i_full_dup && !i_rmii |-> ##[1:3] o_col)
      else $error("heartbeat missing");
   a_speed_follow: assert property (
      i_ce |=> o_speed_indicator == $past(i_speed_100))
      else $error("speed indicator wrong");
   a_link_mode_one: assert property (
      $past(i_rstn) && $past(i_ce) && o_mode == PSI_MODE_1 && $past(o_mode) == PSI_MODE_1
      |-> o_link_indicator == $past(i_link_up))
      else $error("link indicator wrong");
   a_act_mode_three: assert property (
      $past(i_ce) && o_mode == PSI_MODE_3 && $past(o_mode) == PSI_MODE_3
      |-> o_activity_indicator == $past(i_full_dup))
      else $error("duplex indicator wrong");
   c_heartbeat: cover property ($fell(i_tx_en) ##[1:3] o_col);
   c_blink: cover property (o_mode == PSI_MODE_3 && i_link_up && !o_link_indicator);
   c_mode_two: cover property (o_mode == PSI_MODE_2 && o_activity_indicator);
endmodule
